// ===== logic/ssmp_byte_if.sv
// Interface: byte stream between bit shifter and frame core
interface ssmp_byte_if;
  logic       active;  // Frame selected and port enabled
  logic       valid;   // One-cycle pulse, rx_byte complete
  logic [7:0] rx_byte; // Byte from host, MSB first
  logic [7:0] tx_byte; // Byte to send in next slot
  modport shifter (output active, output valid, output rx_byte, input tx_byte);
  modport core    (input active, input valid, input rx_byte, output tx_byte);
endinterface

// ===== logic/ssmp_core.sv
// Serial slave memory port: frame decode, memory and flash access, APB
module ssmp_core (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        host_select_n,
  input  wire logic        host_serial_clock,
  input  wire logic        host_serial_in,
  output logic             host_serial_out,
  output logic             host_serial_out_oe,
  output logic      [15:0] mem_addr,
  output logic      [7:0]  mem_wdata,
  output logic             mem_we,
  output logic             mem_re,
  input  wire logic [7:0]  mem_rdata,
  output logic      [14:0] flash_addr,
  output logic      [15:0] flash_wdata,
  output logic             flash_we,
  output logic             flash_re,
  output logic             flash_erase,
  input  wire logic [15:0] flash_rdata,
  input  wire logic        watchdog_reset,
  output logic             app_halt,
  output logic             host_port_irq_flag
);
  // ---------------------------------------------------------------
  // Key lookup, used by decode and check
  // ---------------------------------------------------------------
  function automatic logic [15:0] key_of(input logic [1:0] step);
    case (step)
      2'h0:    key_of = ssmp_pkg::KEY0;
      2'h1:    key_of = ssmp_pkg::KEY1;
      default: key_of = ssmp_pkg::KEY2;
    endcase
  endfunction

  ssmp_byte_if bi ();                // Byte stream
  logic [2:0]  pins_s;               // Synced select, clock, data
  ssmp_pkg::ssmp_state_e st_r;       // Frame state
  logic [7:0]  cmd_r;                // Frame command
  logic [15:0] addr_r;               // Running address
  logic [7:0]  lo_r;                 // Even flash byte held
  logic [1:0]  step_r;               // Unlock progress
  logic        fm_r;                 // Flash program mode
  logic        en_r;                 // Port enable
  logic        safe_r;               // Safe mode
  logic [7:0]  hcmd_r;               // Host command byte
  logic        fetch_r;              // Read issued last cycle
  logic        fetch_odd_r;          // Fetched flash byte select
  logic        apb_acc;              // Access phase, reply not yet given
  logic        apb_wr;               // Write lands as pready is sampled
  logic [7:0]  tx_r;                 // Next byte out

  // ---------------------------------------------------------------
  // Pin synchronisers and shifter
  // ---------------------------------------------------------------
  ssmp_sync #(.W(3), .RST(3'b100)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({host_select_n, host_serial_clock, host_serial_in}),
    .q       (pins_s)
  );
  ssmp_shift u_shift (
    .pclk      (pclk),
    .presetn   (presetn),
    .port_en   (en_r),
    .sel_n_s   (pins_s[2]),
    .sclk_s    (pins_s[1]),
    .mosi_s    (pins_s[0]),
    .bi        (bi.shifter),
    .miso_r    (host_serial_out),
    .miso_oe_r (host_serial_out_oe)
  );
  assign bi.tx_byte = tx_r;

  // ---------------------------------------------------------------
  // Decode of the current byte
  // ---------------------------------------------------------------
  wire        byte_go  = bi.valid;
  wire        in_al    = byte_go & (st_r == ssmp_pkg::ST_AL);
  wire        in_data  = byte_go & (st_r == ssmp_pkg::ST_DATA);
  wire [15:0] full_adr = {addr_r[15:8], bi.rx_byte};
  wire        is_read  = (cmd_r == ssmp_pkg::CMD_READ);
  wire        is_wr    = (cmd_r == ssmp_pkg::CMD_WRITE);
  wire        is_wr_q  = (cmd_r == ssmp_pkg::CMD_WRITE_Q);
  wire        in_win   = (addr_r >= ssmp_pkg::SAFE_LO) & (addr_r <= ssmp_pkg::SAFE_HI);
  wire        wr_ok    = ~safe_r | in_win;
  wire        wr_go    = in_data & (is_wr | is_wr_q);
  wire        ram_wr   = wr_go & ~fm_r & wr_ok;
  wire        fl_wr    = wr_go & fm_r;
  wire        irq_set  = (ram_wr & is_wr & (addr_r < ssmp_pkg::IORAM_BASE))
                       | (in_data & (cmd_r == ssmp_pkg::CMD_HOST_CMD));
  wire        rd_first = in_al & is_read;
  wire        rd_next  = in_data & is_read;
  wire [15:0] rd_adr   = rd_first ? full_adr : addr_r + 16'h0001;
  wire        key_hit  = (full_adr == key_of(step_r));
  wire        unlock   = in_al & (cmd_r == ssmp_pkg::CMD_UNLOCK);

  // ---------------------------------------------------------------
  // Frame state machine
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= ssmp_pkg::ST_CMD;
    end else if (!bi.active) begin
      st_r <= ssmp_pkg::ST_CMD;
    end else if (byte_go) begin
      case (st_r)
        ssmp_pkg::ST_CMD: st_r <= ssmp_pkg::ST_AH;
        ssmp_pkg::ST_AH:  st_r <= ssmp_pkg::ST_AL;
        ssmp_pkg::ST_AL:  st_r <= ssmp_pkg::ST_DATA;
        default:          st_r <= ssmp_pkg::ST_DATA;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Command and address capture
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_r  <= 8'h00;
      addr_r <= 16'h0000;
    end else if (byte_go) begin
      if (st_r == ssmp_pkg::ST_CMD) cmd_r <= bi.rx_byte;
      if (st_r == ssmp_pkg::ST_AH)  addr_r[15:8] <= bi.rx_byte;
      if (st_r == ssmp_pkg::ST_AL)  addr_r[7:0] <= bi.rx_byte;
      if (st_r == ssmp_pkg::ST_DATA) addr_r <= addr_r + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // Unlock sequence and flash mode
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_r <= 2'h0;
      fm_r   <= 1'b0;
    end else if (watchdog_reset) begin
      step_r <= 2'h0;
      fm_r   <= 1'b0;
    end else if (byte_go && st_r == ssmp_pkg::ST_CMD &&
                 bi.rx_byte != ssmp_pkg::CMD_UNLOCK) begin
      step_r <= 2'h0; // Any other command breaks the sequence
    end else if (unlock) begin
      step_r <= key_hit ? step_r + 2'h1 : 2'h0;
      if (key_hit && step_r == ssmp_pkg::KEY_LAST) begin
        fm_r   <= 1'b1;
        step_r <= 2'h0;
      end
    end
  end

  // ---------------------------------------------------------------
  // RAM bus and flash bus requests
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_addr    <= 16'h0000;
      mem_wdata   <= 8'h00;
      mem_we      <= 1'b0;
      mem_re      <= 1'b0;
      flash_addr  <= 15'h0000;
      flash_wdata <= 16'h0000;
      flash_we    <= 1'b0;
      flash_re    <= 1'b0;
      flash_erase <= 1'b0;
      lo_r        <= 8'h00;
    end else begin
      mem_we      <= ram_wr;
      mem_re      <= (rd_first | rd_next) & ~fm_r;
      flash_re    <= (rd_first | rd_next) & fm_r;
      flash_erase <= in_al & fm_r & (cmd_r == ssmp_pkg::CMD_ERASE);
      flash_we    <= fl_wr & addr_r[0];
      if (ram_wr) begin
        mem_addr  <= addr_r;
        mem_wdata <= bi.rx_byte;
      end
      if (rd_first | rd_next) begin
        mem_addr   <= rd_adr;
        flash_addr <= rd_adr[15:1];
      end
      if (in_al & (cmd_r == ssmp_pkg::CMD_ERASE)) flash_addr <= full_adr[15:1];
      if (fl_wr & ~addr_r[0]) lo_r <= bi.rx_byte;
      if (fl_wr & addr_r[0]) begin
        flash_addr  <= addr_r[15:1];
        flash_wdata <= {bi.rx_byte, lo_r};
      end
    end
  end

  // ---------------------------------------------------------------
  // Read return: capture data into next transmit byte
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fetch_r     <= 1'b0;
      fetch_odd_r <= 1'b0;
      tx_r        <= ssmp_pkg::TX_IDLE;
    end else begin
      fetch_r <= rd_first | rd_next;
      if (rd_first | rd_next) begin
        fetch_odd_r <= rd_adr[0];
      end
      if (fetch_r) begin
        if (fm_r) begin
          tx_r <= fetch_odd_r ? flash_rdata[15:8] : flash_rdata[7:0];
        end else begin
          tx_r <= mem_rdata;
        end
      end else if (byte_go & ~is_read) begin
        tx_r <= ssmp_pkg::TX_IDLE; // Non-read frames send zeros; after a read frame, from their third byte on
      end
    end
  end

  // ---------------------------------------------------------------
  // Halt, host command, activity flag
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      app_halt           <= 1'b0;
      hcmd_r             <= 8'h00;
      host_port_irq_flag <= 1'b0;
    end else begin
      app_halt <= fm_r & ~watchdog_reset;
      if (in_data & (cmd_r == ssmp_pkg::CMD_HOST_CMD) & ~fm_r) begin
        hcmd_r <= bi.rx_byte;
      end
      if (irq_set & ~fm_r) begin
        host_port_irq_flag <= 1'b1; // set wins over clear
      end else if (apb_wr & (paddr == ssmp_pkg::REG_STATUS) &
                   pwdata[ssmp_pkg::STAT_IRQ_BIT]) begin
        host_port_irq_flag <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // APB slave, one wait state
  // ---------------------------------------------------------------
  assign apb_acc = psel & penable & ~pready;
  assign apb_wr  = psel & penable & pready & pwrite; // Same edge the master sees pready
  wire mapped  = (paddr == ssmp_pkg::REG_CTRL) | (paddr == ssmp_pkg::REG_STATUS)
               | (paddr == ssmp_pkg::REG_HOST_CMD);
  wire [31:0] rd_mux =
      (paddr == ssmp_pkg::REG_CTRL)   ? {30'h0, safe_r, en_r} :
      (paddr == ssmp_pkg::REG_STATUS) ? {29'h0, bi.active, host_port_irq_flag, fm_r} :
      (paddr == ssmp_pkg::REG_HOST_CMD) ? {24'h0, hcmd_r} : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
      en_r    <= ssmp_pkg::CTRL_EN_RST;
      safe_r  <= ssmp_pkg::CTRL_SAFE_RST;
    end else begin
      pready  <= apb_acc;
      pslverr <= apb_acc & ~mapped;
      prdata  <= (apb_acc & ~pwrite) ? rd_mux : 32'h0;
      if (apb_wr & (paddr == ssmp_pkg::REG_CTRL)) begin
        en_r   <= pwdata[ssmp_pkg::CTRL_EN_BIT];
        safe_r <= pwdata[ssmp_pkg::CTRL_SAFE_BIT];
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_halt;
    @(posedge pclk) disable iff (!presetn)
    (fm_r && !watchdog_reset) |=> app_halt;
  endproperty
  a_halt: assert property (p_halt) else $error("halt missing in flash mode");

  property p_stay;
    @(posedge pclk) disable iff (!presetn)
    (fm_r && !watchdog_reset) |=> fm_r;
  endproperty
  a_stay: assert property (p_stay) else $error("flash mode left without reset");

  property p_safe;
    @(posedge pclk) disable iff (!presetn)
    (mem_we && $past(safe_r)) |-> (mem_addr >= ssmp_pkg::SAFE_LO && mem_addr <= ssmp_pkg::SAFE_HI);
  endproperty
  a_safe: assert property (p_safe) else $error("write outside safe window");

  property p_noflash;
    @(posedge pclk) disable iff (!presetn)
    (flash_we || flash_re || flash_erase) |-> $past(fm_r);
  endproperty
  a_noflash: assert property (p_noflash) else $error("flash access outside flash mode");

  property p_noram;
    @(posedge pclk) disable iff (!presetn)
    $past(fm_r) |-> !(mem_we || mem_re);
  endproperty
  a_noram: assert property (p_noram) else $error("RAM access in flash mode");

  property p_odd;
    @(posedge pclk) disable iff (!presetn)
    (fl_wr && !addr_r[0]) |=> !flash_we;
  endproperty
  a_odd: assert property (p_odd) else $error("flash word written on even byte");

  property p_off;
    @(posedge pclk) disable iff (!presetn)
    !en_r |=> !host_serial_out_oe;
  endproperty
  a_off: assert property (p_off) else $error("port drives while disabled");

  property p_irq;
    @(posedge pclk) disable iff (!presetn)
    (ram_wr && is_wr_q && !host_port_irq_flag) |=> !host_port_irq_flag;
  endproperty
  a_irq: assert property (p_irq) else $error("quiet write raised flag");
endmodule

// ===== logic/ssmp_pkg.sv
// Package: constants shared by the serial memory port files
package ssmp_pkg;
  // ---------------------------------------------------------------
  // Register map (byte addresses on APB)
  // ---------------------------------------------------------------
  localparam logic [7:0]  REG_CTRL      = 8'h00; // Enable and safe bits
  localparam logic [7:0]  REG_STATUS    = 8'h04; // Mode, flag, busy
  localparam logic [7:0]  REG_HOST_CMD  = 8'h08; // Last host command byte
  localparam int          CTRL_EN_BIT   = 0;     // Port enable
  localparam int          CTRL_SAFE_BIT = 1;     // Safe mode
  localparam int          STAT_FM_BIT   = 0;     // Flash program mode
  localparam int          STAT_IRQ_BIT  = 1;     // Write flag, write 1 clears
  localparam int          STAT_BUSY_BIT = 2;     // Frame in progress
  localparam logic        CTRL_EN_RST   = 1'b1;  // Port on after reset
  localparam logic        CTRL_SAFE_RST = 1'b0;  // Safe mode off after reset
  // ---------------------------------------------------------------
  // Serial commands (first byte of a frame)
  // ---------------------------------------------------------------
  localparam logic [7:0]  CMD_READ      = 8'h03; // Read n bytes
  localparam logic [7:0]  CMD_WRITE     = 8'h02; // Write, raise flag below I/O RAM
  localparam logic [7:0]  CMD_WRITE_Q   = 8'h0A; // Write, no flag
  localparam logic [7:0]  CMD_HOST_CMD  = 8'h40; // Command to processor
  localparam logic [7:0]  CMD_ERASE     = 8'hE0; // Flash erase at address
  localparam logic [7:0]  CMD_UNLOCK    = 8'hA5; // Unlock step, key in address
  // ---------------------------------------------------------------
  // Address map and unlock keys
  // ---------------------------------------------------------------
  localparam logic [15:0] SAFE_LO       = 16'h0400; // Safe window start
  localparam logic [15:0] SAFE_HI       = 16'h040F; // Safe window end
  localparam logic [15:0] IORAM_BASE    = 16'h2000; // I/O RAM start
  localparam logic [15:0] KEY0          = 16'h5AA5; // Unlock key, step 0
  localparam logic [15:0] KEY1          = 16'hC33C; // Unlock key, step 1
  localparam logic [15:0] KEY2          = 16'h0FF0; // Unlock key, step 2
  localparam logic [1:0]  KEY_LAST      = 2'h2;     // Final unlock step
  localparam logic [7:0]  TX_IDLE       = 8'h00;    // Data sent in non-read frames; after a read frame, from their third byte on
  // Frame states, Gray along the usual path
  typedef enum logic [1:0] {
    ST_CMD  = 2'b00,
    ST_AH   = 2'b01,
    ST_AL   = 2'b11,
    ST_DATA = 2'b10
  } ssmp_state_e;
endpackage

// ===== logic/ssmp_shift.sv
// Bit shifter: serial mode 0, MSB first, sampled on pclk
module ssmp_shift (
  input  wire logic    pclk,
  input  wire logic    presetn,
  input  wire logic    port_en,
  input  wire logic    sel_n_s,
  input  wire logic    sclk_s,
  input  wire logic    mosi_s,
  ssmp_byte_if.shifter bi,
  output logic         miso_r,
  output logic         miso_oe_r
);
  logic       sclk_d_r; // Previous synced clock
  logic [2:0] cnt_r;    // Bits taken in this byte
  logic [7:0] sin_r;    // Receive shifter
  logic [7:0] sout_r;   // Transmit shifter
  wire        rise   = sclk_s & ~sclk_d_r;
  wire        fall   = ~sclk_s & sclk_d_r;
  wire        active = ~sel_n_s & port_en;
  // ---------------------------------------------------------------
  // Edge find, shift in on rise, shift out on fall
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_d_r   <= 1'b0;
      cnt_r      <= 3'h0;
      sin_r      <= 8'h00;
      sout_r     <= 8'h00;
      miso_r     <= 1'b0;
      miso_oe_r  <= 1'b0;
      bi.active  <= 1'b0;
      bi.valid   <= 1'b0;
      bi.rx_byte <= 8'h00;
    end else begin
      sclk_d_r  <= sclk_s;
      bi.active <= active;
      miso_oe_r <= active;
      bi.valid  <= active & rise & (cnt_r == 3'h7);
      if (!active) begin
        cnt_r <= 3'h0;      // Frame ends, restart byte count
      end else if (rise) begin
        sin_r <= {sin_r[6:0], mosi_s};
        cnt_r <= cnt_r + 3'h1;
        if (cnt_r == 3'h7) begin
          bi.rx_byte <= {sin_r[6:0], mosi_s};
        end
      end else if (fall) begin
        if (cnt_r == 3'h0) begin
          miso_r <= bi.tx_byte[7]; // Byte slot, load new byte
          sout_r <= {bi.tx_byte[6:0], 1'b0};
        end else begin
          miso_r <= sout_r[7];
          sout_r <= {sout_r[6:0], 1'b0};
        end
      end
    end
  end
endmodule

// ===== logic/ssmp_sync.sv
// Two-flop synchroniser for pin inputs
module ssmp_sync #(
  parameter int          W   = 3,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r; // First stage, read by second only
  genvar i;
  // ---------------------------------------------------------------
  // Per-bit double registers
  // ---------------------------------------------------------------
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_r[i] <= RST[i];
          q[i]      <= RST[i];
        end else begin
          meta_r[i] <= d[i];
          q[i]      <= meta_r[i];
        end
      end
    end
  endgenerate
endmodule

// ===== tb/spi_slave_memory_port_tb.sv
// Self-checking bench for the serial memory port
module spi_slave_memory_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0, presetn = 1'b0, wdog = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, mem_wdata, mem_rdata, we_d;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, sel_n, sclk, mosi, miso, oe;
  logic        mem_we, mem_re, f_we, f_re, f_er, halt, irq;
  logic [15:0] mem_addr, we_a, f_wd, f_rd, fw_d;
  logic [14:0] f_a, fw_a;
  logic [7:0]  rx[$];
  logic [15:0] keys[3] = '{ssmp_pkg::KEY0, ssmp_pkg::KEY1, ssmp_pkg::KEY2};
  int          fail_count = 0, cmp_count = 0, we_n = 0, fwe_n = 0, fer_n = 0, k;
  int          re_n = 0, fre_n = 0, oe_n = 0, j;
  always #4 pclk = ~pclk;
  // Memory models: data derived from address
  assign mem_rdata = mem_addr[7:0] ^ 8'hA5;
  assign f_rd = {f_a[7:0] ^ 8'h3C, f_a[7:0]};
  ssmp_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .host_select_n(sel_n), .host_serial_clock(sclk),
    .host_serial_in(mosi), .host_serial_out(miso), .host_serial_out_oe(oe),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_re(mem_re),
    .mem_rdata(mem_rdata), .flash_addr(f_a), .flash_wdata(f_wd), .flash_we(f_we),
    .flash_re(f_re), .flash_erase(f_er), .flash_rdata(f_rd), .watchdog_reset(wdog),
    .app_halt(halt), .host_port_irq_flag(irq));
  ssmp_host_model i_host (.pclk(pclk), .sel_n(sel_n), .sclk(sclk), .mosi(mosi),
    .miso(miso));
  // Bus monitor: count and capture write pulses
  always @(posedge pclk) begin
    if (mem_we === 1'b1) begin
      we_n++;
      we_a = mem_addr;
      we_d = mem_wdata;
    end
    if (f_we === 1'b1) begin
      fwe_n++;
      fw_a = f_a;
      fw_d = f_wd;
    end
    if (f_er === 1'b1)
      fer_n++;
    if (mem_re === 1'b1)
      re_n++;
    if (f_re === 1'b1)
      fre_n++;
    if (oe === 1'b1)
      oe_n++;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask
  // APB transfer, waits for pready under a bound
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      fail_count++;
      results();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic fr(input logic [7:0] t[$]);
    i_host.frame(t, rx);
  endtask
  task automatic results();
    $display("Comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (100000) @(posedge pclk);
    fail_count++;
    results();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(0, ssmp_pkg::REG_CTRL, 0);
    chk("ctrl", 32'h1, rd);
    apb(0, 8'h0C, 0);
    chk("unmapped_err", 1, err);
    $display("test reset done");
    fr({ssmp_pkg::CMD_WRITE, 8'h01, 8'h00, 8'h55});
    chk("we_addr", 16'h0100, we_a);
    chk("we_data", 8'h55, we_d);
    chk("irq", 1, irq);
    chk("oe_on", 1, oe_n > 0);
    apb(1, ssmp_pkg::REG_STATUS, 32'h2);
    chk("irq_clr", 0, irq);
    fr({ssmp_pkg::CMD_WRITE_Q, 8'h20, 8'h01, 8'hAA});
    chk("we_addr", 16'h2001, we_a);
    chk("irq_quiet", 0, irq);
    fr({ssmp_pkg::CMD_WRITE_Q, 8'h01, 8'h05, 8'h5A});
    chk("we_quiet", 16'h0105, we_a);
    chk("irq_quiet_ram", 0, irq);
    fr({ssmp_pkg::CMD_READ, 8'h01, 8'h23, 8'h00, 8'h00});
    chk("rd0", 8'h86, rx[3]);
    chk("rd1", 8'h81, rx[4]);
    chk("mem_re_cnt", 3, re_n);
    fr({ssmp_pkg::CMD_HOST_CMD, 8'h00, 8'h00, 8'h3C});
    apb(0, ssmp_pkg::REG_HOST_CMD, 0);
    chk("host_cmd", 32'h3C, rd);
    apb(1, ssmp_pkg::REG_STATUS, 32'h2);
    $display("test ram access done");
    apb(1, ssmp_pkg::REG_CTRL, 32'h3);
    k = we_n;
    fr({ssmp_pkg::CMD_WRITE, 8'h04, 8'h10, 8'h77});
    chk("safe_drop", k, we_n);
    fr({ssmp_pkg::CMD_WRITE, 8'h04, 8'h0F, 8'h66});
    chk("safe_win", 16'h040F, we_a);
    apb(1, ssmp_pkg::REG_CTRL, 32'h0);
    k = we_n;
    j = oe_n;
    fr({ssmp_pkg::CMD_WRITE_Q, 8'h01, 8'h02, 8'h11});
    chk("disabled", k, we_n);
    chk("oe_off", j, oe_n);
    apb(1, ssmp_pkg::REG_CTRL, 32'h1);
    $display("test safe and enable done");
    fr({ssmp_pkg::CMD_ERASE, 8'h00, 8'h20});
    chk("erase_off", 0, fer_n);
    fr({ssmp_pkg::CMD_UNLOCK, keys[0][15:8], keys[0][7:0]});
    fr({ssmp_pkg::CMD_UNLOCK, keys[1][15:8], keys[1][7:0]});
    fr({ssmp_pkg::CMD_UNLOCK, keys[1][15:8], keys[1][7:0]});
    chk("halt_bad_key", 0, halt);
    foreach (keys[i]) begin
      chk("halt_pre", (i == 0) ? 0 : 0, halt);
      fr({ssmp_pkg::CMD_UNLOCK, keys[i][15:8], keys[i][7:0]});
    end
    chk("halt", 1, halt);
    apb(0, ssmp_pkg::REG_STATUS, 0);
    chk("fm_bit", 1, rd[0]);
    k = we_n;
    fr({ssmp_pkg::CMD_WRITE_Q, 8'h01, 8'h04, 8'h12});
    chk("ram_blocked", k, we_n);
    fr({ssmp_pkg::CMD_WRITE, 8'h00, 8'h10, 8'h11, 8'h22});
    chk("fwe_cnt", 1, fwe_n);
    chk("fw_addr", 15'h0008, fw_a);
    chk("fw_data", 16'h2211, fw_d);
    k = re_n;
    fr({ssmp_pkg::CMD_READ, 8'h00, 8'h21, 8'h00, 8'h00});
    chk("fl_rd0", 8'h2C, rx[3]);
    chk("fl_rd1", 8'h11, rx[4]);
    chk("fl_re_cnt", 3, fre_n);
    chk("ram_rd_fm", k, re_n);
    fr({ssmp_pkg::CMD_ERASE, 8'h04, 8'h00});
    chk("erase_on", 1, fer_n);
    wdog <= 1'b1;
    @(posedge pclk);
    wdog <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("halt_wdog", 0, halt);
    $display("test flash mode done");
    apb(1, ssmp_pkg::REG_CTRL, 32'h2);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(0, ssmp_pkg::REG_CTRL, 0);
    chk("ctrl_rst", 32'h1, rd);
    fr({ssmp_pkg::CMD_WRITE_Q, 8'h03, 8'h00, 8'h42});
    chk("we_after_rst", 16'h0300, we_a);
    $display("test mid-run reset done");
    results();
  end
endmodule

// ===== tb/ssmp_host_model.sv
// Host master model driving serial frames into the memory port
module ssmp_host_model (
  input  wire logic pclk,
  output logic      sel_n,
  output logic      sclk,
  output logic      mosi,
  input  wire logic miso
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle: deselected, clock low
  initial begin
    sel_n = 1'b1;
    sclk  = 1'b0;
    mosi  = 1'b0;
  end
  // One frame, mode 0, MSB first, 64 ns link period
  task automatic frame(input logic [7:0] tx[$], output logic [7:0] rx[$]);
    logic [7:0] b;
    rx = {};
    sel_n <= 1'b0;
    foreach (tx[i]) begin
      for (int k = 7; k >= 0; k--) begin
        mosi <= tx[i][k];
        sclk <= 1'b0;
        repeat (4) @(posedge pclk);
        b = {b[6:0], miso};
        sclk <= 1'b1;
        repeat (4) @(posedge pclk);
      end
      rx.push_back(b);
    end
    sclk <= 1'b0;
    repeat (4) @(posedge pclk);
    sel_n <= 1'b1;
    // Released line shows the inverse of its last value
    mosi <= ~mosi;
    repeat (12) @(posedge pclk);
  endtask
endmodule
